// ---- hot_swap_pkg.sv ----
// Shared constants and carrier types for the hot-swap status and configuration registers.
// Assumes one 50 MHz clock; all sense inputs already synchronous to it.
package hot_swap_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RAIL12_LIMIT_PG_ORING_CFG = 8'h03;
	localparam logic [7:0] REG_RAIL12_FAULT_ENABLE_CFG = 8'h04;
	localparam logic [7:0] REG_LATCHED_CHANNEL_STATUS = 8'h07;
	localparam logic [7:0] REG_LATCHED_OVERCURRENT_STATUS = 8'h08;
	localparam logic [7:0] REG_LIVE_FET_STATUS = 8'h09;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] LIMIT_PG_ORING_RESET = 8'hbf;
	localparam logic [7:0] FAULT_ENABLE_RESET = 8'h01;
	localparam int CL_LSB = 0;
	localparam int PG_LSB = 4;
	localparam int HP_BIT = 6;
	localparam int OR_BIT = 7;
	localparam int FT_LSB = 0;
	localparam int EN_BIT = 5;
	localparam int UV_BIT = 6;
	localparam int DS_BIT = 7;
	localparam int FLAG_LSB = 4;
	localparam int FLAG_WIDTH = 4;
	localparam int FET_BS_BIT = 3;
	localparam int FET_PS_BIT = 4;
	localparam int FET_IO_BIT = 5;
	localparam int FET_GS_BIT = 7;

	// ----------------------------------------------------------------
	// Timing and serial bus
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int FAULT_STEP_NS = 500000;
	localparam int FAULT_STEP_CYCLES = FAULT_STEP_NS / CLK_PERIOD_NS;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic hiPgAbove;
		logic loPgAbove;
		logic hiCurLimit;
		logic hiFastTrip;
		logic loCurLimit;
		logic loFastTrip;
		logic loFaultExpired;
		logic hiBelowBleed;
		logic hiOringForward;
		logic hiPassAboveOut;
		logic loInAboveOut;
		logic loGateOn;
	} sense_t;

	typedef struct packed {
		logic passDrive;
		logic blockingFetDrive;
		logic bleedConnect;
		logic positiveOring;
		logic [3:0] currentLimitCode;
		logic [1:0] pgThresholdCode;
	} drive_t;

	typedef enum logic [1:0] {
		RAIL_OFF = 2'h0,
		RAIL_WAIT = 2'h1,
		RAIL_ON = 2'h3,
		RAIL_FAULT = 2'h2
	} rail_state_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_ADDR = 3'h1,
		BUS_AACK = 3'h3,
		BUS_WR = 3'h2,
		BUS_WACK = 3'h6,
		BUS_RD = 3'h7,
		BUS_RACK = 3'h5
	} bus_state_t;

endpackage

// ---- flag_latch_bank.sv ----
// Bank of sticky event flags cleared by a read strobe.
// Assumes event and clear inputs are synchronous one-cycle or level terms.
`timescale 1ns/10ps
module flag_latch_bank (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Events and clear
	input wire logic [hot_swap_pkg::FLAG_WIDTH-1:0] evt,
	input wire logic clearRead,
	// Flags
	output logic [hot_swap_pkg::FLAG_WIDTH-1:0] flags
);
	import hot_swap_pkg::*;

	typedef struct packed {
		logic [FLAG_WIDTH-1:0] flags;
	} bank_t;

	bank_t s_q;
	bank_t s_d;

	// ----------------------------------------------------------------
	// Latch
	// ----------------------------------------------------------------
	// An event landing on the clearing read stays set, so nothing is lost
	always_comb begin
		s_d = s_q;
		s_d.flags = evt | (s_q.flags & ~{FLAG_WIDTH{clearRead}});
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flags;

	a_set_over_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clearRead && (evt != '0) |=> ((flags & $past(evt)) == $past(evt)))
		else $error("event lost on clearing read");

endmodule

// ---- hot_swap_status_config_regs.sv ----
// Status and configuration registers of a dual-rail hot-swap controller, with serial target.
// Assumes sense inputs and bus pins are synchronous to ref_clk and the bus is far slower.
//
// Summary of operation
// - Channel status register is read-only; reading it clears its latched flags.
// - Bit 4 latches when the high rail output drops below power good.
// - Bit 5 latches when the high rail fault timer expires.
// - Bit 6 latches when the low rail output drops below power good.
// - Bit 7 latches when the low rail fault timer expires.
// - Overcurrent register is read-only; reading it clears its latched flags.
// - Overcurrent bit 4 latches on high rail current limit.
// - Overcurrent bit 5 latches on high rail fast trip.
// - Overcurrent bit 6 latches on low rail current limit.
// - Overcurrent bit 7 latches on low rail fast trip.
// - FET status is live; bit 4 low on pass gate up, bit 5 low on input above output.
// - FET status bit 3 mirrors the commanded blocking drive.
// - FET status bit 7 reads low while the low rail gate is driven on.
// - Four-bit current limit code, all ones for maximum, drives the limiter.
// - Two-bit power good threshold code, 11 highest, 00 lowest.
// - Positive ORing bit selects the positive turn-off threshold.
// - Clearing ORing allow holds the blocking drive low.
// - Five-bit fault time code sets the timer in half-millisecond steps.
// - Clearing master enable drives pass and blocking gates low.
// - Start-below-bleed holds off turn-on until output drops below bleed threshold.
// - Clearing the bleed bit disconnects the bleed resistor.
// - Fault time code resets to one, the shortest time.
`timescale 1ns/10ps
module hot_swap_status_config_regs #(
	parameter int FAULT_STEP_LEN = hot_swap_pkg::FAULT_STEP_CYCLES,
	parameter logic [3:0] DEV_ADDR_HI = 4'h5 // Arbitrary value
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial bus
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	input wire logic [2:0] addrStrap,
	// Analog side
	input wire hot_swap_pkg::sense_t sense,
	output hot_swap_pkg::drive_t drive
);
	import hot_swap_pkg::*;

	typedef struct packed {
		bus_state_t bus;
		logic [3:0] bitCnt;
		logic [7:0] shifter;
		logic rw;
		logic firstByte;
		logic ackd;
		logic [7:0] pointer;
		logic sclQ;
		logic sdaQ;
		logic [7:0] cfgA;
		logic [7:0] cfgB;
		rail_state_t rail;
		logic [14:0] prescale;
		logic [4:0] steps;
		logic hiPgQ;
		logic loPgQ;
		logic blocking_fet_drive;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic clrChan;
	logic clrOc;
	logic evtFault;
	logic doLoad;
	logic [FLAG_WIDTH-1:0] chanEvt;
	logic [FLAG_WIDTH-1:0] ocEvt;
	logic [FLAG_WIDTH-1:0] chanFlags;
	logic [FLAG_WIDTH-1:0] ocFlags;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic enable;
	logic [7:0] chanView;
	logic [7:0] fetView;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] regRead(input logic [7:0] idx);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			REG_RAIL12_LIMIT_PG_ORING_CFG: r = s_q.cfgA;
			REG_RAIL12_FAULT_ENABLE_CFG: r = s_q.cfgB;
			REG_LATCHED_CHANNEL_STATUS: r[FLAG_LSB +: FLAG_WIDTH] = chanFlags;
			REG_LATCHED_OVERCURRENT_STATUS: r[FLAG_LSB +: FLAG_WIDTH] = ocFlags;
			REG_LIVE_FET_STATUS: begin
				r[FET_BS_BIT] = s_q.blocking_fet_drive;
				r[FET_PS_BIT] = ~sense.hiPassAboveOut;
				r[FET_IO_BIT] = ~sense.loInAboveOut;
				r[FET_GS_BIT] = ~sense.loGateOn;
			end
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bus conditions
	// ----------------------------------------------------------------
	assign sclRise = sclIn && !s_q.sclQ;
	assign sclFall = !sclIn && s_q.sclQ;
	assign startSeen = sclIn && s_q.sclQ && s_q.sdaQ && !sdaIn;
	assign stopSeen = sclIn && s_q.sclQ && !s_q.sdaQ && sdaIn;
	assign enable = s_q.cfgB[EN_BIT];

	// ----------------------------------------------------------------
	// Event sources for the latched registers
	// ----------------------------------------------------------------
	// Power good loss is an above-to-below crossing, not a low level
	assign chanEvt = {sense.loFaultExpired,
		s_q.loPgQ && !sense.loPgAbove,
		evtFault,
		s_q.hiPgQ && !sense.hiPgAbove};
	assign ocEvt = {sense.loFastTrip,
		sense.loCurLimit,
		sense.hiFastTrip,
		sense.hiCurLimit};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		clrChan = 1'b0;
		clrOc = 1'b0;
		evtFault = 1'b0;
		doLoad = 1'b0;
		s_d.sclQ = sclIn;
		s_d.sdaQ = sdaIn;
		s_d.hiPgQ = sense.hiPgAbove;
		s_d.loPgQ = sense.loPgAbove;
		// Serial target: bits sampled on rising clock, line changed on falling
		if (startSeen) begin
			s_d.bus = BUS_ADDR;
			s_d.bitCnt = 4'h0;
			s_d.firstByte = 1'b1;
		end else if (stopSeen) begin
			s_d.bus = BUS_IDLE;
		end else if (sclRise) begin
			case (s_q.bus)
				BUS_ADDR, BUS_WR: begin
					s_d.shifter = {s_q.shifter[6:0], sdaIn};
					s_d.bitCnt = s_q.bitCnt + 4'h1;
				end
				BUS_RD: s_d.bitCnt = s_q.bitCnt + 4'h1;
				BUS_RACK: s_d.ackd = !sdaIn;
				default: ;
			endcase
		end else if (sclFall) begin
			case (s_q.bus)
				BUS_ADDR: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						if (s_q.shifter[7:1] == {DEV_ADDR_HI, addrStrap}) begin
							s_d.bus = BUS_AACK;
							s_d.rw = s_q.shifter[0];
						end else begin
							s_d.bus = BUS_IDLE;
						end
					end
				end
				BUS_AACK: begin
					if (s_q.rw) begin
						doLoad = 1'b1;
					end else begin
						s_d.bus = BUS_WR;
						s_d.bitCnt = 4'h0;
					end
				end
				BUS_WR: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						s_d.bus = BUS_WACK;
						if (s_q.firstByte) begin
							s_d.pointer = s_q.shifter;
							s_d.firstByte = 1'b0;
						end else begin
							// Status registers are read-only; writes to them vanish
							case (s_q.pointer)
								REG_RAIL12_LIMIT_PG_ORING_CFG: s_d.cfgA = s_q.shifter;
								REG_RAIL12_FAULT_ENABLE_CFG: s_d.cfgB = s_q.shifter;
								default: ;
							endcase
							s_d.pointer = s_q.pointer + 8'h01;
						end
					end
				end
				BUS_WACK: begin
					s_d.bus = BUS_WR;
					s_d.bitCnt = 4'h0;
				end
				BUS_RD: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						s_d.bus = BUS_RACK;
					end else begin
						s_d.shifter = {s_q.shifter[6:0], 1'b0};
					end
				end
				BUS_RACK: begin
					if (s_q.ackd) begin
						doLoad = 1'b1;
					end else begin
						s_d.bus = BUS_IDLE;
					end
				end
				default: s_d.bus = BUS_IDLE;
			endcase
		end
		// Capturing a byte for transmit is the read that clears the flags
		if (doLoad) begin
			s_d.shifter = regRead(s_q.pointer);
			s_d.pointer = s_q.pointer + 8'h01;
			s_d.bus = BUS_RD;
			s_d.bitCnt = 4'h0;
			clrChan = (s_q.pointer == REG_LATCHED_CHANNEL_STATUS);
			clrOc = (s_q.pointer == REG_LATCHED_OVERCURRENT_STATUS);
		end
		// High rail fault timer: runs only while limiting in the on state
		if (s_q.rail == RAIL_ON && sense.hiCurLimit) begin
			if (s_q.prescale == 15'(FAULT_STEP_LEN - 1)) begin
				s_d.prescale = 15'h0000;
				s_d.steps = s_q.steps + 5'h01;
				if (s_d.steps >= s_q.cfgB[FT_LSB +: 5]) begin
					evtFault = 1'b1;
				end
			end else begin
				s_d.prescale = s_q.prescale + 15'h0001;
			end
		end else begin
			s_d.prescale = 15'h0000;
			s_d.steps = 5'h00;
		end
		// High rail sequencing
		case (s_q.rail)
			RAIL_OFF: begin
				if (enable) begin
					if (s_q.cfgB[UV_BIT] && !sense.hiBelowBleed) begin
						s_d.rail = RAIL_WAIT;
					end else begin
						s_d.rail = RAIL_ON;
					end
				end
			end
			RAIL_WAIT: begin
				if (!enable) begin
					s_d.rail = RAIL_OFF;
				end else if (sense.hiBelowBleed) begin
					s_d.rail = RAIL_ON;
				end
			end
			RAIL_ON: begin
				if (!enable) begin
					s_d.rail = RAIL_OFF;
				end else if (evtFault) begin
					s_d.rail = RAIL_FAULT;
				end
			end
			// A timed-out channel stays off until the enable is cycled
			RAIL_FAULT: begin
				if (!enable) begin
					s_d.rail = RAIL_OFF;
				end
			end
			default: s_d.rail = RAIL_OFF;
		endcase
		s_d.blocking_fet_drive = (s_d.rail == RAIL_ON) && enable && s_q.cfgA[OR_BIT]
			&& sense.hiOringForward;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.bus <= BUS_IDLE;
			s_q.rail <= RAIL_OFF;
			s_q.sclQ <= 1'b1;
			s_q.sdaQ <= 1'b1;
			s_q.cfgA <= LIMIT_PG_ORING_RESET;
			s_q.cfgB <= FAULT_ENABLE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Latched flag banks
	// ----------------------------------------------------------------
	flag_latch_bank chanBank (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.evt(chanEvt),
		.clearRead(clrChan),
		.flags(chanFlags)
	);

	flag_latch_bank ocBank (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.evt(ocEvt),
		.clearRead(clrOc),
		.flags(ocFlags)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open-drain data line: only ever pulled low
	assign sdaOut = 1'b0;
	assign sdaOe_n = !((s_q.bus == BUS_AACK) || (s_q.bus == BUS_WACK)
		|| (s_q.bus == BUS_RD && !s_q.shifter[7]));
	assign drive.passDrive = (s_q.rail == RAIL_ON);
	assign drive.blockingFetDrive = s_q.blocking_fet_drive;
	assign drive.bleedConnect = s_q.cfgB[DS_BIT];
	assign drive.positiveOring = s_q.cfgA[HP_BIT];
	assign drive.currentLimitCode = s_q.cfgA[CL_LSB +: 4];
	assign drive.pgThresholdCode = s_q.cfgA[PG_LSB +: 2];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Register images for the checks: a function called inside an assertion would
	// read post-edge values while its neighbours are sampled before the edge
	always_comb begin
		chanView = regRead(REG_LATCHED_CHANNEL_STATUS);
		fetView = regRead(REG_LIVE_FET_STATUS);
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_chan_read_clears: assert property (clrChan && chanEvt == '0 |=> chanFlags == '0)
		else $error("channel flags not cleared by read");
	a_oc_read_clears: assert property (clrOc && ocEvt == '0 |=> ocFlags == '0)
		else $error("overcurrent flags not cleared by read");
	a_hi_pg_latch: assert property (s_q.hiPgQ && !sense.hiPgAbove && !clrChan
		|=> chanFlags[0] ##1 (chanFlags[0] || $past(clrChan)))
		else $error("power good loss not latched");
	a_fault_sets_flag: assert property (evtFault |=> chanFlags[1] && !drive.passDrive)
		else $error("fault expiry not latched");
	a_hi_oc_latch: assert property (sense.hiCurLimit |=> ocFlags[0])
		else $error("current limit not latched");
	a_oring_gate: assert property (!s_q.cfgA[OR_BIT] |=> !drive.blockingFetDrive)
		else $error("blocking drive high with ORing disallowed");
	a_enable_off: assert property (!enable |=> !drive.passDrive && !drive.blockingFetDrive)
		else $error("gates driven while disabled");
	a_start_hold: assert property (s_q.rail == RAIL_OFF && enable && s_q.cfgB[UV_BIT]
		&& !sense.hiBelowBleed |=> !drive.passDrive
		##1 (!drive.passDrive || $past(sense.hiBelowBleed)))
		else $error("turn-on before bleed-down");
	a_spare_zero: assert property ((chanView & 8'h0f) == 8'h00
		&& (fetView & 8'h47) == 8'h00)
		else $error("spare bits not zero");
	a_fet_live: assert property (fetView == {~sense.loGateOn, 1'b0, ~sense.loInAboveOut,
		~sense.hiPassAboveOut, drive.blockingFetDrive, 3'h0})
		else $error("fet status not live");

endmodule

// ---- i2c_host_model.sv ----
// Two-wire bus host that reads and writes the hot-swap register target.
// Assumes the target samples both lines on ref_clk; a pull-up holds released data high.
`timescale 1ns/10ps
module i2c_host_model #(
	parameter logic [6:0] DEV = 7'h2a
) (
	// Clock
	input wire logic ref_clk,
	// Bus lines
	input wire logic sdaOut,
	input wire logic sdaOe_n,
	output logic sclIn,
	output logic sdaIn
);
	logic sdaRel;

	// Wired-AND of both parties; a released line floats up to one
	assign sdaIn = sdaRel & (sdaOe_n | sdaOut);

	initial begin
		sclIn = 1'b1;
		sdaRel = 1'b1;
	end

	// ----------------------------------------------------------------
	// Bit level
	// ----------------------------------------------------------------
	// Four-cycle phases: twice the minimum, so one cycle of target lag is harmless
	task automatic bitx(input logic b, output logic r);
		@(posedge ref_clk) sdaRel <= b;
		repeat (3) @(posedge ref_clk);
		sclIn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		r = sdaIn;
		repeat (2) @(posedge ref_clk);
		sclIn <= 1'b0;
	endtask

	task automatic start();
		@(posedge ref_clk) sdaRel <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sclIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sdaRel <= 1'b0;
		repeat (4) @(posedge ref_clk);
		sclIn <= 1'b0;
	endtask

	task automatic stop();
		@(posedge ref_clk) sdaRel <= 1'b0;
		repeat (3) @(posedge ref_clk);
		sclIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sdaRel <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] r,
		output logic ackIn);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(ackOut, ackIn);
	endtask

	// ----------------------------------------------------------------
	// Register level
	// ----------------------------------------------------------------
	task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic a;
		start();
		xfer({DEV, 1'b0}, 1'b1, r, a);
		xfer(idx, 1'b1, r, a);
		xfer(d, 1'b1, r, a);
		stop();
	endtask

	// Single byte read; the NACK ends the transfer
	task automatic rdReg(input logic [7:0] idx, output logic [7:0] d);
		logic [7:0] r;
		logic a;
		start();
		xfer({DEV, 1'b0}, 1'b1, r, a);
		xfer(idx, 1'b1, r, a);
		start();
		xfer({DEV, 1'b1}, 1'b1, r, a);
		xfer(8'hff, 1'b1, d, a);
		stop();
	endtask
endmodule

// ---- hot_swap_status_config_regs_tb.sv ----
// Self-checking bench for the hot-swap register block, driven through the bus host model.
// Assumes a shortened fault step so that fault-timer runs stay brief.
`timescale 1ns/10ps
module hot_swap_status_config_regs_tb;
	import hot_swap_pkg::*;
	localparam int STEP = 4;
	logic ref_clk;
	logic rst_n;
	logic sclIn;
	logic sdaIn;
	logic sdaOut;
	logic sdaOe_n;
	sense_t sense;
	drive_t drive;
	int failCount;
	int nChecks;
	int cycles;
	logic [7:0] rd;

	hot_swap_status_config_regs #(.FAULT_STEP_LEN(STEP), .DEV_ADDR_HI(4'h5))
		hot_swap_status_config_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrStrap(3'h2), .sense(sense),
		.drive(drive));
	i2c_host_model #(.DEV(7'h2a)) i2c_host_model_inst (.ref_clk(ref_clk), .sdaOut(sdaOut),
		.sdaOe_n(sdaOe_n), .sclIn(sclIn), .sdaIn(sdaIn));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		i2c_host_model_inst.rdReg(idx, rd);
		check(rd, exp);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i2c_host_model_inst.wrReg(idx, d);
	endtask

	// A hang ends the run as a mismatch
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failCount++;
			stopTest();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] cfg [3];
		int n;
		cfg = '{8'h00, 8'h65, 8'h9a};
		rst_n = 1'b0;
		sense = '0;
		failCount = 0;
		nChecks = 0;
		cycles = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check({drive.currentLimitCode, drive.pgThresholdCode, drive.positiveOring,
			drive.passDrive}, 8'hfc);
		rc(8'h03, 8'hbf);
		rc(8'h04, 8'h01);
		rc(8'h07, 8'h00);
		rc(8'h08, 8'h00);
		rc(8'h09, 8'hb0);
		rc(8'h02, 8'h00);
		foreach (cfg[i]) begin
			wr(8'h03, cfg[i]);
			check({2'h0, drive.currentLimitCode, drive.pgThresholdCode},
				{2'h0, cfg[i][3:0], cfg[i][5:4]});
			check({7'h0, drive.positiveOring}, {7'h0, cfg[i][6]});
			rc(8'h03, cfg[i]);
		end
		wr(8'h03, 8'hbf);
		wr(8'h07, 8'hff);
		rc(8'h07, 8'h00);
		// Each power good loss alone, then the clearing read
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk) sense[11 - i] <= 1'b1;
			@(posedge ref_clk) sense[11 - i] <= 1'b0;
			rc(8'h07, 8'(8'h10 << (2 * i)));
			rc(8'h07, 8'h00);
		end
		@(posedge ref_clk) sense.loFaultExpired <= 1'b1;
		@(posedge ref_clk) sense.loFaultExpired <= 1'b0;
		rc(8'h07, 8'h80);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) sense[9 - i] <= 1'b1;
			@(posedge ref_clk) sense[9 - i] <= 1'b0;
			rc(8'h08, 8'(8'h10 << i));
		end
		rc(8'h08, 8'h00);
		@(posedge ref_clk) sense[2:0] <= 3'h7;
		rc(8'h09, 8'h00);
		@(posedge ref_clk) sense[2:0] <= 3'h6;
		rc(8'h09, 8'h80);
		@(posedge ref_clk) sense[3:0] <= 4'h8;
		// Turn-on held off until the output has bled down
		wr(8'h04, 8'h60);
		repeat (20) @(posedge ref_clk);
		check({7'h0, drive.passDrive}, 8'h00);
		@(posedge ref_clk) sense.hiBelowBleed <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check({6'h0, drive.passDrive, drive.blockingFetDrive}, 8'h03);
		rc(8'h09, 8'hb8);
		wr(8'h03, 8'h3f);
		check({6'h0, drive.passDrive, drive.blockingFetDrive}, 8'h02);
		rc(8'h09, 8'hb0);
		wr(8'h03, 8'hbf);
		wr(8'h04, 8'he0);
		check({7'h0, drive.bleedConnect}, 8'h01);
		wr(8'h04, 8'h40);
		check({6'h0, drive.passDrive, drive.blockingFetDrive}, 8'h00);
		check({7'h0, drive.bleedConnect}, 8'h00);
		// Fault code 3: the channel must drop after three steps of current limit
		wr(8'h04, 8'h23);
		check({7'h0, drive.passDrive}, 8'h01);
		n = 0;
		@(posedge ref_clk) sense.hiCurLimit <= 1'b1;
		@(negedge ref_clk);
		while (drive.passDrive === 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		check(8'(n >= 3 * STEP - 1 && n <= 3 * STEP + 3), 8'h01);
		rc(8'h07, 8'h20);
		// Limit still active: the clearing read coincides with a live event
		rc(8'h08, 8'h10);
		@(posedge ref_clk) sense.hiCurLimit <= 1'b0;
		rc(8'h08, 8'h10);
		rc(8'h08, 8'h00);
		stopTest();
	end
endmodule
